// >>> sim/dprcos_ram_checker.sv
// Port A assertions of the two-port RAM output stage, bound into every dprcos_ram.
// Assumes static mode inputs and one common clock for both ports.
`default_nettype none

module dprcos_ram_checker (
	input wire logic                      i_clock,
	input wire logic                      i_rst,
	input wire logic                      i_true_dual_port_config,
	input wire dprcos_pkg::dprcos_wmode_t i_wmode_a,
	input wire logic                      i_prim_reg_a,
	input wire logic                      i_core_reg_a,
	input wire logic                      i_use_regce,
	input wire logic                      i_reset_over_enable_priority,
	input wire dprcos_pkg::dprcos_req_t   i_req_a,
	input wire dprcos_pkg::dprcos_req_t   i_req_b,
	input wire dprcos_pkg::dprcos_octl_t  i_octl_a,
	input wire logic                      i_ecc_single_a,
	input wire logic                      i_ecc_double_a,
	input wire dprcos_pkg::dprcos_rsp_t   o_rsp_a
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// No register stage means the latch drives the port; any B access to the address is a hit.
	wire nr  = !i_prim_reg_a && !i_core_reg_a;
	wire rg  = i_prim_reg_a || i_core_reg_a;
	wire hit = i_req_b.en && (i_req_b.addr == i_req_a.addr);

	// A lone port A access, so collision effects cannot blur the expected output.
	sequence s_solo;
		nr && i_true_dual_port_config && i_req_a.en && !i_octl_a.rst && !hit;
	endsequence

	a_latch_rst: assert property (
		nr && !i_use_regce && i_req_a.en && i_octl_a.rst |=> o_rsp_a.dout == 32'h0000_0000)
		else $error("latch reset missed");
	a_latch_hold: assert property (
		nr && !i_use_regce && !i_req_a.en |=> $stable(o_rsp_a)) else $error("latch moved");
	a_new_data: assert property (
		s_solo ##0 (i_wmode_a == dprcos_pkg::DPRCOS_NEW_DATA && &i_req_a.we)
		|=> o_rsp_a.dout == $past(i_req_a.din)) else $error("new data not shown");
	a_hold_write: assert property (
		s_solo ##0 (i_wmode_a == dprcos_pkg::DPRCOS_HOLD_OUTPUT && |i_req_a.we)
		|=> $stable(o_rsp_a.dout)) else $error("hold mode output moved");
	a_flag_align: assert property (
		nr && i_req_a.en && !i_octl_a.rst && i_req_a.we == 4'h0 |=> {o_rsp_a.single_bit_error_flag,
		o_rsp_a.double_bit_error_flag} == $past({i_ecc_single_a, i_ecc_double_a}))
		else $error("flags misaligned");
	a_reg_no_en: assert property (
		!i_use_regce && rg && !i_req_a.en && !i_octl_a.rst |=> $stable(o_rsp_a))
		else $error("register moved without enable");
	a_regce_gate: assert property (
		i_use_regce && rg && !i_octl_a.regce && !(i_octl_a.rst && i_reset_over_enable_priority)
		|=> $stable(o_rsp_a)) else $error("register moved without clock enable");
	a_last_rst: assert property (
		i_use_regce && rg && i_octl_a.rst && (i_octl_a.regce || i_reset_over_enable_priority)
		|=> o_rsp_a.dout == 32'h0000_0000) else $error("last register reset missed");
endmodule : dprcos_ram_checker

bind dprcos_ram dprcos_ram_checker u_dprcos_ram_checker (.*);

`default_nettype wire

// >>> sim/dprcos_ram_tb.sv
// Self-checking bench of the two-port RAM: collisions, byte writes, modes, latency, reset.
// Assumes the package, the design and the user model are compiled first.
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", n, e, s); end end

module dprcos_ram_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic i_clock, i_rst, i_true_dual_port_config, i_prim_reg_a, i_prim_reg_b, i_core_reg_a;
	logic i_core_reg_b, i_use_regce, i_reset_over_enable_priority, i_ecc_single_a;
	logic i_ecc_double_a, i_ecc_single_b, i_ecc_double_b;
	logic [1:0]                i_mux_stages;
	dprcos_pkg::dprcos_wmode_t i_wmode_a, i_wmode_b;
	dprcos_pkg::dprcos_req_t   i_req_a, i_req_b;
	dprcos_pkg::dprcos_octl_t  i_octl_a, i_octl_b;
	dprcos_pkg::dprcos_rsp_t   o_rsp_a, o_rsp_b;
	int                        num_errors = 0;
	int                        checks = 0;
	int                        cyc = 0;
	localparam dprcos_pkg::dprcos_req_t IDLE = '0;

	dprcos_ram u_dprcos_ram (.*);
	dprcos_user u_dprcos_user (.i_clock(i_clock), .o_req_a(i_req_a), .o_req_b(i_req_b));

	// 50 MHz clock.
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	// A hang is cut short well beyond the few dozen cycles the tests need.
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			num_errors++;
			end_sim();
		end
	end

	function automatic dprcos_pkg::dprcos_req_t rq(input logic [7:0] a,
		input logic [3:0] w = 4'h0, input logic [31:0] d = 32'h0000_0000);
		return '{1'b1, w, a, d};
	endfunction : rq

	task automatic put(input dprcos_pkg::dprcos_req_t a, input dprcos_pkg::dprcos_req_t b);
		u_dprcos_user.put(a, b);
	endtask : put

	task automatic t_collide();
		put(rq(8'h10, 4'hF, 32'h1122_3344), IDLE);
		put(rq(8'h10, 4'hF, 32'hAABB_CCDD), rq(8'h10));
		put(rq(8'h10), IDLE);
		`CHK("collide b", 32'h1122_3344, o_rsp_b.dout)
		`CHK("collide a", 32'h1122_3344, o_rsp_a.dout)
		put(IDLE, IDLE);
		`CHK("stored", 32'hAABB_CCDD, o_rsp_a.dout)
	endtask : t_collide

	task automatic t_bytes();
		put(rq(8'h20, 4'h3, 32'h1111_2222), rq(8'h20, 4'hC, 32'h3333_4444));
		put(rq(8'h20), IDLE);
		put(IDLE, IDLE);
		`CHK("bytes", 32'h3333_2222, o_rsp_a.dout)
	endtask : t_bytes

	task automatic t_modes();
		i_wmode_a = dprcos_pkg::DPRCOS_NEW_DATA;
		put(rq(8'h30, 4'hF, 32'h5555_6666), IDLE);
		put(IDLE, IDLE);
		`CHK("new", 32'h5555_6666, o_rsp_a.dout)
		i_wmode_a = dprcos_pkg::DPRCOS_HOLD_OUTPUT;
		put(rq(8'h30, 4'hF, 32'h7777_8888), IDLE);
		put(rq(8'h30), IDLE);
		`CHK("hold", 32'h5555_6666, o_rsp_a.dout)
		put(IDLE, IDLE);
		`CHK("after hold", 32'h7777_8888, o_rsp_a.dout)
		i_wmode_a = dprcos_pkg::DPRCOS_OLD_DATA;
		i_octl_a.rst = 1'b1;
		put(rq(8'h30), IDLE);
		`CHK("rst no en", 32'h7777_8888, o_rsp_a.dout)
		put(IDLE, IDLE);
		`CHK("latch rst", 32'h0000_0000, o_rsp_a.dout)
		i_octl_a.rst = 1'b0;
	endtask : t_modes

	task automatic t_sdp();
		i_true_dual_port_config = 1'b0;
		put(rq(8'h40, 4'hF, 32'h0000_0001), rq(8'h40, 4'hF, 32'h0000_0009));
		put(rq(8'h40, 4'hF, 32'h0000_0002), rq(8'h40));
		put(IDLE, IDLE);
		`CHK("simple", 32'h0000_0001, o_rsp_b.dout)
		i_true_dual_port_config = 1'b1;
	endtask : t_sdp

	// Primitive, two mux and core stages: five cycles; then the output controls.
	task automatic t_latency();
		{i_prim_reg_a, i_core_reg_a, i_core_reg_b, i_mux_stages} = 5'h1E;
		{i_ecc_single_a, i_ecc_double_a, i_rst} = 3'h7;
		put(IDLE, IDLE);
		i_rst = 1'b0;
		repeat (5) put(rq(8'h10), IDLE);
		`CHK("early", {32'h0000_0000, 2'h0}, o_rsp_a)
		put(rq(8'h10), IDLE);
		`CHK("late", {32'hAABB_CCDD, 2'h3}, o_rsp_a)
		repeat (2) put(IDLE, IDLE);
		`CHK("no en", {32'hAABB_CCDD, 2'h3}, o_rsp_a)
		i_use_regce = 1'b1;
		i_octl_a = 2'h2;
		put(IDLE, IDLE);
		`CHK("gated", {32'hAABB_CCDD, 2'h3}, o_rsp_a)
		i_reset_over_enable_priority = 1'b1;
		put(IDLE, IDLE);
		`CHK("priority", 32'h0000_0000, o_rsp_a.dout)
	endtask : t_latency

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// Reset for eight cycles, then the scenarios in order.
	initial begin
		{i_rst, i_true_dual_port_config, i_prim_reg_a, i_prim_reg_b, i_core_reg_a} = 5'h18;
		{i_core_reg_b, i_use_regce, i_reset_over_enable_priority, i_ecc_single_a} = 4'h0;
		{i_ecc_double_a, i_ecc_single_b, i_ecc_double_b, i_mux_stages} = 5'h00;
		{i_octl_a, i_octl_b} = 4'h0;
		i_wmode_a = dprcos_pkg::DPRCOS_OLD_DATA;
		i_wmode_b = dprcos_pkg::DPRCOS_OLD_DATA;
		repeat (8) @(posedge i_clock);
		#1 i_rst = 1'b0;
		t_collide();
		t_bytes();
		t_modes();
		t_sdp();
		t_latency();
		end_sim();
	end
endmodule : dprcos_ram_tb

`default_nettype wire

// >>> sim/dprcos_user.sv
// User logic on both RAM ports: one request pair per clock.
// Assumes the bench calls put from one process only.
`default_nettype none

module dprcos_user (
	input wire logic                    i_clock,
	output var dprcos_pkg::dprcos_req_t o_req_a,
	output var dprcos_pkg::dprcos_req_t o_req_b
);
	timeunit 1ns;
	timeprecision 1ns;

	// Launch just after the edge and hold a full cycle; idle data lines toggle, never stay valid.
	task automatic put(input dprcos_pkg::dprcos_req_t a, input dprcos_pkg::dprcos_req_t b);
		// One shared clock, so a full cycle between accesses is the separation asked for.
		@(posedge i_clock);
		#1;
		if (!a.en) a.din = ~o_req_a.din;
		if (!b.en) b.din = ~o_req_b.din;
		o_req_a = a;
		o_req_b = b;
	endtask : put

	// Ports idle from time zero.
	initial begin
		o_req_a = '0;
		o_req_b = '0;
	end
endmodule : dprcos_user

`default_nettype wire

// >>> src/dprcos_pkg.sv
// Constants, modes and carrier types for the two-port RAM with collision handling
// and a configurable read output stage.
// Assumes one common clock for both ports and synchronous user logic on each port.
// Operation
// - Common-clock write-write same word gives unknown.
// - Byte writes: only doubly written bytes corrupt.
// - Write-read collision never corrupts stored contents.
// - Old-data writer: reader gets previous contents.
// - New-data or hold writer: reader output undefined.
// - Byte writes: only written bytes invalid to reader.
// - Simple dual-port: A writes, B reads, fixed mode.
// - Simple dual-port common clock behaves old-data.
// - Simple dual-port mode follows clocking selection.
// - Primitive and core registers selectable per port.
// - Each output register stage adds one cycle.
// - Up to three mux stages, core registers needed.
// - Mux depth shared, 1 to 3, one cycle each.
// - Error flags delayed alongside read data.
// - Register clock enable gates the last register.
// - Reset acts on last register or latch.
// - Reset with enable drives configured reset value.
// - Old-data mode shows previous contents on write.
// - New-data mode shows written data on write.
// - Hold mode leaves output latch unchanged on write.
// - Priority: clock enable or reset dominates.
`default_nettype none

package dprcos_pkg;

	localparam int unsigned DATA_W   = 32;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned BYTES    = DATA_W / BYTE_W;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DEPTH    = 256;
	localparam int unsigned MUX_MAX  = 3;
	localparam int unsigned STAGES   = MUX_MAX + 2;

	// Output reset value and the pattern stored or shown when a byte turns undefined.
	localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;
	localparam logic [BYTE_W-1:0] BAD_BYTE    = 8'hXX;

	// Per-port write behaviour.
	typedef enum logic [1:0] {
		DPRCOS_OLD_DATA,
		DPRCOS_NEW_DATA,
		DPRCOS_HOLD_OUTPUT
	} dprcos_wmode_t;

	// Request bundle driven by the user logic on one port.
	typedef struct packed {
		logic               en;
		logic [BYTES-1:0]   we;
		logic [ADDR_W-1:0]  addr;
		logic [DATA_W-1:0]  din;
	} dprcos_req_t;

	// Output-stage controls of one port.
	typedef struct packed {
		logic               rst;
		logic               regce;
	} dprcos_octl_t;

	// Read answer with its aligned error flags.
	typedef struct packed {
		logic [DATA_W-1:0]  dout;
		logic               single_bit_error_flag;
		logic               double_bit_error_flag;
	} dprcos_rsp_t;

endpackage : dprcos_pkg

`default_nettype wire

// >>> src/dprcos_ram.sv
// Two-port synchronous RAM with collision semantics and configurable output stages.
// Both ports share i_clock; mode selections are static inputs held by the system.
`default_nettype none

module dprcos_ram (
	input  wire logic                              i_clock,
	input  wire logic                              i_rst,
	input  wire logic                              i_true_dual_port_config,
	input  wire dprcos_pkg::dprcos_wmode_t         i_wmode_a,
	input  wire dprcos_pkg::dprcos_wmode_t         i_wmode_b,
	input  wire logic                              i_prim_reg_a,
	input  wire logic                              i_prim_reg_b,
	input  wire logic                              i_core_reg_a,
	input  wire logic                              i_core_reg_b,
	input  wire logic [1:0]                        i_mux_stages,
	input  wire logic                              i_use_regce,
	input  wire logic                              i_reset_over_enable_priority,
	input  wire dprcos_pkg::dprcos_req_t           i_req_a,
	input  wire dprcos_pkg::dprcos_req_t           i_req_b,
	input  wire dprcos_pkg::dprcos_octl_t          i_octl_a,
	input  wire dprcos_pkg::dprcos_octl_t          i_octl_b,
	input  wire logic                              i_ecc_single_a,
	input  wire logic                              i_ecc_double_a,
	input  wire logic                              i_ecc_single_b,
	input  wire logic                              i_ecc_double_b,
	output var  dprcos_pkg::dprcos_rsp_t           o_rsp_a,
	output var  dprcos_pkg::dprcos_rsp_t           o_rsp_b
);

	localparam int unsigned DW = dprcos_pkg::DATA_W;
	localparam int unsigned BW = dprcos_pkg::BYTE_W;
	localparam int unsigned NB = dprcos_pkg::BYTES;
	localparam int unsigned NS = dprcos_pkg::STAGES;

	// Effective requests: simple dual-port clears B's write enables, so only A writes; both ports still read.
	dprcos_pkg::dprcos_req_t   req_a;
	dprcos_pkg::dprcos_req_t   req_b;
	dprcos_pkg::dprcos_wmode_t mode_a;
	dprcos_pkg::dprcos_wmode_t mode_b;
	logic                      same_addr;

	// Simple dual-port is fixed to old-data behaviour since both ports share one clock.
	always_comb begin
		req_a  = i_req_a;
		req_b  = i_req_b;
		mode_a = i_wmode_a;
		mode_b = i_wmode_b;
		if (!i_true_dual_port_config) begin
			req_b.we = '0;
			mode_a   = dprcos_pkg::DPRCOS_OLD_DATA;
			mode_b   = dprcos_pkg::DPRCOS_OLD_DATA;
		end
		same_addr = req_a.en && req_b.en && (req_a.addr == req_b.addr);
	end

	// Memory array held in flip-flops.
	logic [DW-1:0] mem_q [dprcos_pkg::DEPTH];
	logic [DW-1:0] mem_d [dprcos_pkg::DEPTH];
	logic [DW-1:0] old_a;
	logic [DW-1:0] old_b;

	assign old_a = mem_q[req_a.addr];
	assign old_b = mem_q[req_b.addr];

	// Byte-wise next memory; a byte written by both ports turns undefined, others store.
	always_comb begin
		mem_d = mem_q;
		for (int k = 0; k < NB; k++) begin
			if (req_a.en && req_a.we[k]) begin
				mem_d[req_a.addr][k*BW +: BW] = req_a.din[k*BW +: BW];
			end
			if (req_b.en && req_b.we[k]) begin
				mem_d[req_b.addr][k*BW +: BW] = req_b.din[k*BW +: BW];
			end
			if (same_addr && req_a.we[k] && req_b.we[k]) begin
				mem_d[req_a.addr][k*BW +: BW] = dprcos_pkg::BAD_BYTE;
			end
		end
	end

	// Reads never write the array, so a write-read collision leaves contents intact.
	always_ff @(posedge i_clock) begin
		mem_q <= mem_d;
	end

	// Latch next values: own-port write mode, then cross-port collision damage.
	logic [DW-1:0] latch_a_d;
	logic [DW-1:0] latch_b_d;

	function automatic logic [DW-1:0] latch_next(
		input dprcos_pkg::dprcos_req_t   own,
		input dprcos_pkg::dprcos_wmode_t own_mode,
		input logic [DW-1:0]             own_old,
		input logic [DW-1:0]             cur,
		input dprcos_pkg::dprcos_req_t   other,
		input dprcos_pkg::dprcos_wmode_t other_mode,
		input logic                      hit
	);
		logic [DW-1:0] v;
		v = own_old;
		if (own.we != '0) begin
			unique case (own_mode)
				dprcos_pkg::DPRCOS_OLD_DATA:    v = own_old;
				dprcos_pkg::DPRCOS_NEW_DATA: begin
					for (int k = 0; k < NB; k++) begin
						if (own.we[k]) v[k*BW +: BW] = own.din[k*BW +: BW];
					end
				end
				dprcos_pkg::DPRCOS_HOLD_OUTPUT: v = cur;
				default:                        v = own_old;
			endcase
		end
		if (hit && other_mode != dprcos_pkg::DPRCOS_OLD_DATA) begin
			for (int k = 0; k < NB; k++) begin
				if (other.we[k]) v[k*BW +: BW] = dprcos_pkg::BAD_BYTE;
			end
		end
		return v;
	endfunction : latch_next

	// Output pipelines per port: latch, primitive reg, three mux stages, core reg.
	logic [DW+1:0] pipe_q [2][NS+1];
	logic [DW+1:0] pipe_d [2][NS+1];
	logic [NS:0]   used   [2];
	logic [2:0]    last   [2];
	logic          en_p   [2];
	dprcos_pkg::dprcos_octl_t octl [2];
	logic          ecc_s  [2];
	logic          ecc_d  [2];

	assign latch_a_d = latch_next(req_a, mode_a, old_a, pipe_q[0][0][DW+1:2],
		req_b, mode_b, same_addr);
	assign latch_b_d = latch_next(req_b, mode_b, old_b, pipe_q[1][0][DW+1:2],
		req_a, mode_a, same_addr);

	// Stage usage; mux stages need core registers on both ports.
	always_comb begin
		logic mux_ok;
		mux_ok = i_core_reg_a && i_core_reg_b;
		used[0] = {i_core_reg_a, mux_ok && i_mux_stages == 2'h3,
			mux_ok && i_mux_stages >= 2'h2, mux_ok && i_mux_stages >= 2'h1,
			i_prim_reg_a, 1'b1};
		used[1] = {i_core_reg_b, mux_ok && i_mux_stages == 2'h3,
			mux_ok && i_mux_stages >= 2'h2, mux_ok && i_mux_stages >= 2'h1,
			i_prim_reg_b, 1'b1};
		en_p[0]  = req_a.en;
		en_p[1]  = req_b.en;
		octl[0]  = i_octl_a;
		octl[1]  = i_octl_b;
		ecc_s[0] = i_ecc_single_a;
		ecc_d[0] = i_ecc_double_a;
		ecc_s[1] = i_ecc_single_b;
		ecc_d[1] = i_ecc_double_b;
	end

	// Each used stage takes the nearest used stage below it; skipped stages add no cycle.
	generate
		for (genvar p = 0; p < 2; p++) begin : g_port
			always_comb begin
				logic [DW+1:0] src;
				logic          ce;
				logic          rv;
				ce  = 1'b0;
				rv  = 1'b0;
				src = {(p == 0) ? latch_a_d : latch_b_d, ecc_s[p], ecc_d[p]};
				last[p] = 3'h0;
				for (int s = 0; s <= NS; s++) begin
					if (used[p][s]) last[p] = 3'(s);
				end
				for (int s = 0; s <= NS; s++) begin
					pipe_d[p][s] = pipe_q[p][s];
					ce = (i_use_regce && s != 0 && 3'(s) == last[p]) ?
						octl[p].regce : en_p[p];
					rv = octl[p].rst && 3'(s) == last[p];
					if (used[p][s]) begin
						if (rv && (ce || (i_reset_over_enable_priority && s != 0))) begin
							pipe_d[p][s] = {dprcos_pkg::RESET_VALUE, 2'b00};
						end else if (ce) begin
							pipe_d[p][s] = src;
						end
						src = pipe_q[p][s];
					end
				end
			end
		end
	endgenerate

	// Output pipeline registers.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			for (int p = 0; p < 2; p++) begin
				for (int s = 0; s <= NS; s++) pipe_q[p][s] <= '0;
			end
		end else begin
			pipe_q <= pipe_d;
		end
	end

	// Outputs taken from the last used stage's flip-flop.
	assign o_rsp_a = pipe_q[0][last[0]];
	assign o_rsp_b = pipe_q[1][last[1]];

endmodule : dprcos_ram

`default_nettype wire
